// *** hdl/cofr_pkg.sv ***
// shared constants and carriers for the codec offset, flag and filter registers
package cofr_pkg;

   // register addresses on the control port
   localparam logic [7:0] COFR_OFS_ADDR = 8'h0a;  // serial word offset
   localparam logic [7:0] COFR_FLAG_ADDR = 8'h0b; // overflow flags and pll pre-divider
   localparam logic [7:0] COFR_FILT_ADDR = 8'h0c; // digital filter control

   // reset values
   localparam logic [7:0] COFR_OFS_RST = 8'h00;
   localparam logic [3:0] COFR_FLAG_RST = 4'h0;
   localparam logic [3:0] COFR_DIV_RST = 4'h1;
   localparam logic [7:0] COFR_FILT_RST = 8'h00;
   localparam logic [7:0] COFR_UNMAPPED_DATA = 8'h00; // answer to an unmapped read

   // flag register layout: flags in the high nibble, divider in the low one
   localparam int COFR_FLAG_LADC_BIT = 7;
   localparam int COFR_FLAG_RADC_BIT = 6;
   localparam int COFR_FLAG_LDAC_BIT = 5;
   localparam int COFR_FLAG_RDAC_BIT = 4;
   localparam int COFR_FLAG_LSB = 4;
   localparam int COFR_FLAG_CNT = 4;
   localparam int COFR_DIV_MSB = 3;
   localparam int COFR_DIV_LSB = 0;
   localparam logic [3:0] COFR_DIV_WRAP_CODE = 4'h0; // code that means divide by 16
   localparam logic [4:0] COFR_DIV_WRAP_RATIO = 5'h10;

   // filter register layout
   localparam int COFR_HPF_L_MSB = 7;
   localparam int COFR_HPF_L_LSB = 6;
   localparam int COFR_HPF_R_MSB = 5;
   localparam int COFR_HPF_R_LSB = 4;
   localparam int COFR_EFX_L_BIT = 3;
   localparam int COFR_DEEM_L_BIT = 2;
   localparam int COFR_EFX_R_BIT = 1;
   localparam int COFR_DEEM_R_BIT = 0;

   // largest legal data offsets per transfer mode and framing
   localparam logic [7:0] COFR_MAX_CONT_STD = 8'h11; // 17
   localparam logic [7:0] COFR_MAX_CONT_DSP = 8'h10; // 16
   localparam logic [7:0] COFR_MAX_256_STD = 8'hf2;  // 242
   localparam logic [7:0] COFR_MAX_256_DSP = 8'hf1;  // 241

   // serial framing selection, driven from the interface control register
   typedef enum logic [1:0] {
      COFR_FMT_I2S = 2'h0,
      COFR_FMT_DSP = 2'h1,
      COFR_FMT_RIGHT_JUSTIFIED_FORMAT = 2'h2,
      COFR_FMT_LEFT_JUSTIFIED_FORMAT = 2'h3
   } cofr_fmt_t;

   // adc high-pass corner, as a fraction of the adc sample rate
   typedef enum logic [1:0] {
      COFR_HPF_OFF = 2'h0,
      COFR_HPF_0045 = 2'h1,
      COFR_HPF_0125 = 2'h2,
      COFR_HPF_025 = 2'h3
   } cofr_hpf_t;

   // one control-port access
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } cofr_req_t;

   // settings for the filter datapaths
   typedef struct packed {
      cofr_hpf_t hpf_l;
      cofr_hpf_t hpf_r;
      logic efx_l;
      logic deem_l;
      logic efx_r;
      logic deem_r;
   } cofr_filt_t;

   // settings for the serial framing unit
   typedef struct packed {
      logic [7:0] offset;
      logic ref_rising;
      logic bclk256;
      logic offset_in_range;
   } cofr_frame_t;

endpackage

// *** hdl/cofr_sticky_flags.sv ***
`timescale 1ns/1ps
// bank of sticky event flags, cleared together by a read strobe
module cofr_sticky_flags #(
   parameter int N = 4
) (
   input logic clk,
   input logic nrst,
   input logic [N-1:0] set_i,
   input logic clr_i,
   output logic [N-1:0] flags_q
);

   // refuse a bank with no flags
   generate
      if (N < 1)
      begin : g_bad_n
         $error("cofr_sticky_flags needs at least one flag");
      end
   endgenerate

   // next state of every flag, one cell per flag
   wire [N-1:0] flags_d;

   // a set in the clearing cycle wins so no event is lost
   genvar i;
   generate
      for (i = 0; i < N; i++)
      begin : g_cell
         assign flags_d[i] = set_i[i] | (flags_q[i] & ~clr_i);
      end
   endgenerate

   // one register for the whole bank keeps a single driver on the output
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         flags_q <= '0;
      else
         flags_q <= flags_d;
   end

   // a flag stays up until a clear, and a set beats a clear
   a_flag_hold: assert property (@(posedge clk) disable iff (!nrst)
      (flags_q[0] && !clr_i) |=> flags_q[0])
      else $error("sticky flag dropped without a clear");
   a_set_wins: assert property (@(posedge clk) disable iff (!nrst)
      (set_i[N-1] && clr_i) |=> flags_q[N-1])
      else $error("event lost during clear");

endmodule

// *** hdl/cofr_regs.sv ***
`timescale 1ns/1ps
// Operation
// - eight-bit offset register, reset zero, both directions
// - dsp framing counts offset from rising word clock
// - four overflow flags bits 7..4, reset zero
// - overflow flag sets and stays set
// - reading flags returns them then clears
// - left adc high-pass select bits 7:6
// - right adc high-pass select bits 5:4
// - effects filter enables bits 3 and 1
// - de-emphasis enables bits 2 and 0
// - right de-emphasis bit touches only its stage
// - format field picks i2s, dsp, right, left
// - bit clock master plus 256 mode gives 256
module cofr_regs (
   input logic clk,
   input logic nrst,
   input cofr_pkg::cofr_req_t req,
   input cofr_pkg::cofr_fmt_t fmt,
   input logic bclk_is_output,
   input logic xfer256_sel,
   input logic ovf_ladc,
   input logic ovf_radc,
   input logic ovf_ldac,
   input logic ovf_rdac,
   output logic [7:0] rdata,
   output logic rvalid,
   output cofr_pkg::cofr_frame_t frame,
   output logic [3:0] pll_div_code,
   output logic [4:0] pll_div_ratio,
   output cofr_pkg::cofr_filt_t filt
);

   // largest legal offset for a mode and framing
   function automatic logic [7:0] offset_limit(input logic mode256, input cofr_pkg::cofr_fmt_t f);
      logic is_dsp;
      is_dsp = (f == cofr_pkg::COFR_FMT_DSP);
      if (mode256)
         return is_dsp ? cofr_pkg::COFR_MAX_256_DSP : cofr_pkg::COFR_MAX_256_STD;
      else
         return is_dsp ? cofr_pkg::COFR_MAX_CONT_DSP : cofr_pkg::COFR_MAX_CONT_STD;
   endfunction

   // pre-divider code to ratio; the all-zero code wraps to sixteen
   function automatic logic [4:0] div_ratio(input logic [3:0] code);
      if (code == cofr_pkg::COFR_DIV_WRAP_CODE)
         return cofr_pkg::COFR_DIV_WRAP_RATIO;
      else
         return {1'b0, code};
   endfunction

   // two-bit field to high-pass corner, shared by both adc channels
   function automatic cofr_pkg::cofr_hpf_t hpf_decode(input logic [1:0] code);
      return cofr_pkg::cofr_hpf_t'(code);
   endfunction

   // stored register state
   logic [7:0] offset_q; // word offset, in bit clocks
   logic [3:0] div_q; // pll pre-divider code
   logic [7:0] filt_q; // filter control byte
   logic [3:0] flags_q; // ladc, radc, ldac, rdac from msb down
   logic [7:0] rdata_q; // read answer, held until the next read
   logic rvalid_q; // one-cycle answer marker
   cofr_pkg::cofr_frame_t frame_q; // framing settings
   logic [4:0] ratio_q; // decoded divide ratio

   // address decode
   wire sel_ofs = (req.addr == cofr_pkg::COFR_OFS_ADDR);
   wire sel_flag = (req.addr == cofr_pkg::COFR_FLAG_ADDR);
   wire sel_filt = (req.addr == cofr_pkg::COFR_FILT_ADDR);
   wire wr_ofs = req.wr & sel_ofs;
   wire wr_flag = req.wr & sel_flag;
   wire wr_filt = req.wr & sel_filt;
   wire rd_flag = req.rd & sel_flag; // read of the flag byte clears its four flags; the divider nibble is kept

   // overflow events in flag order, from datapaths on this clock
   wire [3:0] ovf_set = {ovf_ladc, ovf_radc, ovf_ldac, ovf_rdac};

   // flag byte as software sees it; writes never reach the high nibble
   wire [7:0] flag_byte = {flags_q, div_q};

   // read mux; unmapped addresses answer zero
   wire [7:0] rd_word = sel_ofs ? offset_q :
                        sel_flag ? flag_byte :
                        sel_filt ? filt_q :
                        cofr_pkg::COFR_UNMAPPED_DATA;

   // framing decode from offset and interface settings
   wire mode256 = bclk_is_output & xfer256_sel;
   wire ref_rising = (fmt == cofr_pkg::COFR_FMT_DSP);
   wire [7:0] limit = offset_limit(mode256, fmt);
   cofr_pkg::cofr_frame_t frame_d;
   assign frame_d.offset = offset_q;
   assign frame_d.ref_rising = ref_rising;
   assign frame_d.bclk256 = mode256;
   assign frame_d.offset_in_range = (offset_q <= limit);

   // sticky overflow flags with clear on read
   cofr_sticky_flags #(
      .N(cofr_pkg::COFR_FLAG_CNT)
   ) u_flags (
      .clk(clk),
      .nrst(nrst),
      .set_i(ovf_set),
      .clr_i(rd_flag),
      .flags_q(flags_q)
   );

   // offset register
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         offset_q <= cofr_pkg::COFR_OFS_RST;
      else if (wr_ofs)
         offset_q <= req.wdata;
   end

   // pre-divider; only the low nibble of a flag-register write lands
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         div_q <= cofr_pkg::COFR_DIV_RST;
      else if (wr_flag)
         div_q <= req.wdata[cofr_pkg::COFR_DIV_MSB:cofr_pkg::COFR_DIV_LSB];
   end

   // filter control byte
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         filt_q <= cofr_pkg::COFR_FILT_RST;
      else if (wr_filt)
         filt_q <= req.wdata;
   end

   // read answer; flags are captured on the same edge that clears them
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         rdata_q <= 8'h00;
         rvalid_q <= 1'b0;
      end
      else
      begin
         rvalid_q <= req.rd;
         if (req.rd)
            rdata_q <= rd_word;
      end
   end

   // framing and divider outputs are registered so downstream sees clean levels
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         frame_q <= '0;
         ratio_q <= {1'b0, cofr_pkg::COFR_DIV_RST}; // constant only, no logic in the reset path
      end
      else
      begin
         frame_q <= frame_d;
         ratio_q <= div_ratio(div_q);
      end
   end

   // outputs; every filter bit is wired to its own stage only
   assign rdata = rdata_q;
   assign rvalid = rvalid_q;
   assign frame = frame_q;
   assign pll_div_code = div_q;
   assign pll_div_ratio = ratio_q;
   assign filt.hpf_l = hpf_decode(filt_q[cofr_pkg::COFR_HPF_L_MSB:cofr_pkg::COFR_HPF_L_LSB]);
   assign filt.hpf_r = hpf_decode(filt_q[cofr_pkg::COFR_HPF_R_MSB:cofr_pkg::COFR_HPF_R_LSB]);
   assign filt.efx_l = filt_q[cofr_pkg::COFR_EFX_L_BIT];
   assign filt.deem_l = filt_q[cofr_pkg::COFR_DEEM_L_BIT];
   assign filt.efx_r = filt_q[cofr_pkg::COFR_EFX_R_BIT];
   assign filt.deem_r = filt_q[cofr_pkg::COFR_DEEM_R_BIT];

   // a write is visible on the offset output two edges later
   a_offset_write: assert property (@(posedge clk) disable iff (!nrst)
      (wr_ofs && !req.rd) |=> ##1 (frame.offset == $past(req.wdata, 2)))
      else $error("offset write not seen on framing output");

   // dsp framing flag follows the format one edge later
   a_dsp_rising: assert property (@(posedge clk) disable iff (!nrst)
      1'b1 |=> (frame.ref_rising == ($past(fmt) == cofr_pkg::COFR_FMT_DSP)))
      else $error("rising reference does not match dsp framing");

   // continuous-mode offset window
   a_cont_limit: assert property (@(posedge clk) disable iff (!nrst)
      (!mode256 && fmt != cofr_pkg::COFR_FMT_DSP) |=>
      (frame.offset_in_range == ($past(offset_q) <= 8'h11)))
      else $error("continuous offset check wrong");

   // 256-clock dsp offset window
   a_dsp256_limit: assert property (@(posedge clk) disable iff (!nrst)
      (mode256 && fmt == cofr_pkg::COFR_FMT_DSP) |=>
      (frame.offset_in_range == ($past(offset_q) <= 8'hf1)))
      else $error("256-clock dsp offset check wrong");

   // 256 clocks only when the bit clock is driven out
   a_bclk256_gate: assert property (@(posedge clk) disable iff (!nrst)
      (!bclk_is_output) |=> !frame.bclk256)
      else $error("256-clock mode with bit clock as input");

   // an overflow shows up in the next flag read
   sequence s_ovf_then_read;
      ovf_ladc ##1 (rd_flag && !ovf_ladc);
   endsequence
   sequence s_answer_set;
      rvalid && rdata[cofr_pkg::COFR_FLAG_LADC_BIT] ##0 !flags_q[3];
   endsequence
   a_read_clear: assert property (@(posedge clk) disable iff (!nrst)
      s_ovf_then_read |=> s_answer_set)
      else $error("flag read did not return then clear");

   // overflow in the read cycle survives the clear
   a_set_on_read: assert property (@(posedge clk) disable iff (!nrst)
      (rd_flag && ovf_rdac) |=> flags_q[0])
      else $error("overflow lost in read cycle");

   // flag write touches the divider only
   a_flag_wr_ro: assert property (@(posedge clk) disable iff (!nrst)
      (wr_flag && !(|ovf_set) && !req.rd) |=>
      (flags_q == $past(flags_q)) && (div_q == $past(req.wdata[3:0])))
      else $error("flag write disturbed the flags or missed the divider");

   // wrap code gives a ratio of sixteen
   a_div_wrap: assert property (@(posedge clk) disable iff (!nrst)
      (div_q == 4'h0) [*2] |-> (pll_div_ratio == 5'h10))
      else $error("divider code zero not sixteen");

   // filter write reaches both high-pass stages and the left effects and de-emphasis stages
   a_filt_write: assert property (@(posedge clk) disable iff (!nrst)
      wr_filt |=> (filt.hpf_l == $past(req.wdata[7:6])) && (filt.hpf_r == $past(req.wdata[5:4])) &&
      (filt.efx_l == $past(req.wdata[3])) && (filt.deem_l == $past(req.wdata[2])))
      else $error("filter control write not applied");

   // toggling only the right de-emphasis bit leaves the rest alone
   a_deem_r_only: assert property (@(posedge clk) disable iff (!nrst)
      (wr_filt && ((req.wdata ^ filt_q) == 8'h01)) |=>
      $stable(filt.hpf_l) && $stable(filt.hpf_r) && $stable(filt.efx_l) &&
      $stable(filt.deem_l) && $stable(filt.efx_r) && $changed(filt.deem_r))
      else $error("right de-emphasis bit leaked into other stages");

   // unmapped reads answer zero
   a_unmapped_zero: assert property (@(posedge clk) disable iff (!nrst)
      (req.rd && !sel_ofs && !sel_flag && !sel_filt) |=> (rvalid && rdata == 8'h00))
      else $error("unmapped read did not return zero");

   // continuous-mode dsp offset window
   a_cont_dsp_limit: assert property (@(posedge clk) disable iff (!nrst)
      (!mode256 && fmt == cofr_pkg::COFR_FMT_DSP) |=>
      (frame.offset_in_range == ($past(offset_q) <= cofr_pkg::COFR_MAX_CONT_DSP)))
      else $error("continuous dsp offset check wrong");

   // 256-clock offset window for the non-dsp framings
   a_std256_limit: assert property (@(posedge clk) disable iff (!nrst)
      (mode256 && fmt != cofr_pkg::COFR_FMT_DSP) |=>
      (frame.offset_in_range == ($past(offset_q) <= cofr_pkg::COFR_MAX_256_STD)))
      else $error("256-clock offset check wrong");

   // every read strobe gets exactly one answer marker, one edge later
   a_rvalid_pulse: assert property (@(posedge clk) disable iff (!nrst)
      1'b1 |=> (rvalid == $past(req.rd)))
      else $error("answer marker does not follow the read strobe");

   // a flag read returns the byte as it stood before the clear
   a_read_return: assert property (@(posedge clk) disable iff (!nrst)
      rd_flag |=> (rvalid && (rdata == $past(flag_byte))))
      else $error("flag read returned the wrong byte");

   // with no event in the read cycle, every flag is cleared
   a_flag_cleared: assert property (@(posedge clk) disable iff (!nrst)
      (rd_flag && !(|ovf_set)) |=> (flags_q == 4'h0))
      else $error("flags not cleared by read");

   // any overflow event raises its own flag on the next edge
   a_ovf_sets: assert property (@(posedge clk) disable iff (!nrst)
      (ovf_set != 4'h0) |=> ((flags_q & $past(ovf_set)) == $past(ovf_set)))
      else $error("overflow event did not set its flag");

   // codes one to fifteen give their own ratio
   a_div_ratio: assert property (@(posedge clk) disable iff (!nrst)
      (div_q != cofr_pkg::COFR_DIV_WRAP_CODE) [*2] |-> (pll_div_ratio == {1'b0, $past(div_q)}))
      else $error("divider ratio does not match its code");

   // the offset only moves on a write to its own address
   a_offset_hold: assert property (@(posedge clk) disable iff (!nrst)
      !wr_ofs |=> $stable(offset_q))
      else $error("offset changed without a write");

   // right-channel dac controls follow the written bits
   a_filt_right: assert property (@(posedge clk) disable iff (!nrst)
      wr_filt |=> (filt.efx_r == $past(req.wdata[1])) && (filt.deem_r == $past(req.wdata[0])))
      else $error("right dac filter controls not applied");

endmodule

// *** verification/cofr_regs_test.sv ***
`timescale 1ns/1ps
// self-checking bench for the offset, flag and filter register bank
module cofr_regs_test;
   logic clk; // 40 mhz device clock
   logic nrst; // async reset, active low
   cofr_pkg::cofr_req_t req; // control-port access
   cofr_pkg::cofr_fmt_t fmt; // serial framing select
   logic bclk_is_output;
   logic xfer256_sel;
   logic [3:0] ovf; // overflow events: ladc, radc, ldac, rdac
   logic [7:0] rdata;
   logic rvalid;
   cofr_pkg::cofr_frame_t frame;
   logic [3:0] pll_div_code;
   logic [4:0] pll_div_ratio;
   cofr_pkg::cofr_filt_t filt;
   int num_errors = 0; // mismatches seen
   int checked = 0; // comparisons made
   integer seed = 32'hefb58cfa; // fixed seed keeps runs repeatable
   logic [7:0] exp_q[$]; // expected read answers, oldest first
   logic [3:0] div; // divider code last written
   logic [7:0] lim; // offset limit for the current mode
   logic [7:0] v;
   cofr_regs u_dut (.clk(clk), .nrst(nrst), .req(req), .fmt(fmt), .bclk_is_output(bclk_is_output),
      .xfer256_sel(xfer256_sel), .ovf_ladc(ovf[3]), .ovf_radc(ovf[2]), .ovf_ldac(ovf[1]),
      .ovf_rdac(ovf[0]), .rdata(rdata), .rvalid(rvalid), .frame(frame), .pll_div_code(pll_div_code),
      .pll_div_ratio(pll_div_ratio), .filt(filt));
   // clock
   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   // one comparison, reported at once on a difference
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // verdict, reached from the main sequence or the watchdog
   task automatic tally_and_finish;
      $display("checks %0d errors %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   // wait n edges, then step off the edge by the drive delay
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #2;
   endtask
   // single write strobe, one idle cycle after it
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      req.wr = 1'b1;
      req.addr = a;
      req.wdata = d;
      cyc(1);
      req.wr = 1'b0;
      cyc(1);
   endtask
   // read strobe with optional overflow events in the same cycle; expected answer goes to the queue
   task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [3:0] ev);
      exp_q.push_back(e);
      req.rd = 1'b1;
      req.addr = a;
      ovf = ev;
      cyc(1);
      req.rd = 1'b0;
      ovf = 4'h0;
      cyc(1);
   endtask
   // read monitor: rvalid stands one cycle, so sample mid-cycle where it is settled
   always @(negedge clk)
   begin
      if (rvalid === 1'b1)
      begin
         if (exp_q.size() == 0)
            chk({7'h0, rvalid}, 8'h00);
         else
            chk(rdata, exp_q.pop_front());
      end
   end
   // watchdog, well beyond the few hundred cycles the sequence needs
   initial
   begin
      #(25 * 20000);
      num_errors++;
      tally_and_finish();
   end
   // main sequence
   initial
   begin
      nrst = 1'b0;
      req = '0;
      fmt = cofr_pkg::COFR_FMT_I2S;
      bclk_is_output = 1'b0;
      xfer256_sel = 1'b0;
      ovf = 4'h0;
      cyc(3);
      nrst = 1'b1;
      // reset values of all three registers and the divider and filter outputs
      rd(cofr_pkg::COFR_OFS_ADDR, 8'h00, 4'h0);
      rd(cofr_pkg::COFR_FLAG_ADDR, 8'h01, 4'h0);
      rd(cofr_pkg::COFR_FILT_ADDR, 8'h00, 4'h0);
      chk({4'h0, pll_div_code}, 8'h01);
      chk({3'h0, pll_div_ratio}, 8'h01);
      chk(filt, 8'h00);
      // offset limits for every framing and transfer mode, at and just past the limit
      for (int f = 0; f < 4; f++)
         for (int m = 0; m < 3; m++)
            for (int k = 0; k < 3; k++)
            begin
               fmt = cofr_pkg::cofr_fmt_t'(f);
               bclk_is_output = (m == 1);
               xfer256_sel = (m != 0);
               lim = (m == 1) ? ((f == 1) ? 8'd241 : 8'd242) : ((f == 1) ? 8'd16 : 8'd17);
               v = (k == 2) ? 8'($random(seed)) : lim + 8'(k);
               wr(cofr_pkg::COFR_OFS_ADDR, v);
               chk(frame.offset, v);
               chk({7'h0, frame.offset_in_range}, {7'h0, v <= lim});
               chk({7'h0, frame.ref_rising}, {7'h0, f == 1});
               chk({7'h0, frame.bclk256}, {7'h0, m == 1});
               rd(cofr_pkg::COFR_OFS_ADDR, v, 4'h0);
            end
      // unmapped write ignored, unmapped read answers zero
      wr(8'h20, 8'h5a);
      rd(cofr_pkg::COFR_OFS_ADDR, v, 4'h0);
      rd(8'h20, cofr_pkg::COFR_UNMAPPED_DATA, 4'h0);
      // every divider code, with random data aimed at the read-only flag bits
      for (int c = 0; c < 16; c++)
      begin
         div = 4'(c);
         wr(cofr_pkg::COFR_FLAG_ADDR, {4'($random(seed)), div});
         chk({4'h0, pll_div_code}, {4'h0, div});
         chk({3'h0, pll_div_ratio}, (c == 0) ? 8'h10 : 8'(c));
         rd(cofr_pkg::COFR_FLAG_ADDR, {4'h0, div}, 4'h0);
      end
      // filter control: walking single bits, then random patterns
      for (int k = 0; k < 14; k++)
      begin
         v = (k < 8) ? 8'h01 << k : 8'($random(seed));
         wr(cofr_pkg::COFR_FILT_ADDR, v);
         chk(filt, v);
         rd(cofr_pkg::COFR_FILT_ADDR, v, 4'h0);
      end
      // each flag sticks after its event goes away and clears on read
      for (int i = 0; i < 4; i++)
      begin
         ovf = 4'h8 >> i;
         cyc(2);
         ovf = 4'h0;
         cyc(3);
         rd(cofr_pkg::COFR_FLAG_ADDR, {4'h8 >> i, div}, 4'h0);
         rd(cofr_pkg::COFR_FLAG_ADDR, {4'h0, div}, 4'h0);
      end
      // event in the same cycle as the read survives it
      ovf = 4'h8;
      cyc(1);
      rd(cofr_pkg::COFR_FLAG_ADDR, {4'h8, div}, 4'h5);
      rd(cofr_pkg::COFR_FLAG_ADDR, {4'h5, div}, 4'h8);
      rd(cofr_pkg::COFR_FLAG_ADDR, {4'h8, div}, 4'h0);
      rd(cofr_pkg::COFR_FLAG_ADDR, {4'h0, div}, 4'h0);
      // reset in mid-run brings every register back
      wr(cofr_pkg::COFR_OFS_ADDR, 8'h33);
      ovf = 4'hf;
      cyc(1);
      ovf = 4'h0;
      nrst = 1'b0;
      cyc(1);
      chk(frame.offset, 8'h00);
      chk({4'h0, pll_div_code}, 8'h01);
      chk(filt, 8'h00);
      chk({3'h0, pll_div_ratio}, 8'h01);
      chk({7'h0, rvalid}, 8'h00);
      nrst = 1'b1;
      cyc(1);
      rd(cofr_pkg::COFR_FLAG_ADDR, 8'h01, 4'h0);
      rd(cofr_pkg::COFR_OFS_ADDR, 8'h00, 4'h0);
      cyc(2);
      chk(8'(exp_q.size()), 8'h00);
      tally_and_finish();
   end
endmodule
